// [logic/bb_pkg.sv]
// Purpose: Shared constants and carrier types for the alternate mode fallback sequencer.
// Assumes: 250 MHz APB clock; all offsets are byte addresses of aligned 32-bit words.
// Notes: Timing figures are kept in their own units and converted to cycles here.
package bb_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TIMER_UNIT_MS = 10;
  localparam int TIMER_UNIT_CYCLES = TIMER_UNIT_MS * CLK_MHZ * 1000;
  localparam int DETACH_US = 100;
  localparam int DETACH_CYCLES = DETACH_US * CLK_MHZ;

  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TIMER_A = 8'h08;
  localparam logic [7:0] OFS_TIMER_B = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_SEQ_STATE = 8'h1c;

  localparam logic [7:0] CONTROL_RESET = 8'h14;
  localparam logic [7:0] CONTROL_MASK = 8'h3f;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int SEL_W = 5;
  localparam int NUM_PINS = 17;
  localparam logic [4:0] SEL_RESERVED = 5'h09;
  localparam logic [4:0] SEL_MAX = 5'h10;
  localparam logic [15:0] TIMER_RESET = 16'h07d0;

  localparam int IRQ_W = 4;
  localparam int IRQ_ENTER_BB = 0;
  localparam int IRQ_EXPIRE_A = 1;
  localparam int IRQ_EXPIRE_B = 2;
  localparam int IRQ_RESTORED = 3;
  localparam logic [1:0] BM_UNSPECIFIED = 2'h0;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_DETACH_BB, ST_BILLBOARD, ST_DETACH_NORM, ST_WAIT_HIGH
  } seq_state_t;

  typedef struct packed {
    logic addr_set;
    logic alt_string_req;
  } func_req_t;

  typedef struct packed {
    logic attach;
    logic billboard;
    logic alt_string_grant;
    logic [1:0] bm_configured;
  } func_rsp_t;
endpackage

// [logic/billboard_mode_sequencer.sv]
// Purpose: Switches the internal function between normal and fallback class roles.
// Assumes: APB slave on pclk; pin inputs and function requests are synchronous to pclk.
// Notes: Detach time and timer unit are parameters so that simulation can shorten them.
//
// Overview of operation
// - Control bits [5:1] pick the failure pin; codes up to 10000, 01001 reserved.
// - Default selection is general_io_68, code 01010.
// - The failure input is active low.
// - Fallback behaviour only while control bit [0] is one.
// - A low failure input first detaches the internal function from the port.
// - Then it re-attaches presenting fallback class descriptors, class revision 1.1.
// - Timer A starts when the host assigns the function an address.
// - Timer A defaults to 20 seconds.
// - Fallback exposed only on mode entry failure; configured field reports 00.
// - An alternate mode string request is answered and starts timer B.
// - Timer B defaults to 20 seconds.
// - Expiry of either timer detaches the fallback function.
// - After that detach the function re-attaches with normal descriptors.
// - Timers load 16 bits in 10 ms units, default 2000 units.
//
// Chosen here: the APB slave port.
module billboard_mode_sequencer #(
  parameter int UNIT_CYCLES = bb_pkg::TIMER_UNIT_CYCLES,
  parameter int DETACH_HOLD = bb_pkg::DETACH_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Candidate failure pins, indexed by selection code
  input wire logic [bb_pkg::NUM_PINS-1:0] general_io,
  // Internal function
  input wire bb_pkg::func_req_t func_req,
  output bb_pkg::func_rsp_t func_rsp,
  // Interrupt
  output logic irq
);
  import bb_pkg::*;
  localparam int DW = $clog2(DETACH_HOLD + 1);

  initial begin
    if (DETACH_HOLD < 1) $error("DETACH_HOLD must be at least one");
  end

  typedef struct packed {
    seq_state_t st;
    logic [DW-1:0] hold;
    logic [7:0] ctrl;
    logic [15:0] tmr_a;
    logic [15:0] tmr_b;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
    logic err;
    logic grant;
  } seq_t;

  seq_t q, d;
  logic exp_a, exp_b;
  logic [SEL_W-1:0] sel;
  logic sel_ok, fail_low, wr, setup;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = wd[7:0];
    if (strb[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_CONTROL || a == OFS_TIMER_A || a == OFS_TIMER_B ||
           a == OFS_IRQ_STATUS || a == OFS_IRQ_CLEAR || a == OFS_IRQ_ENABLE ||
           a == OFS_SEQ_STATE;
  endfunction

  assign sel = q.ctrl[CTRL_SEL_LSB +: SEL_W];
  // A reserved or out-of-range code has no pin behind it.
  assign sel_ok = q.ctrl[CTRL_ENABLE_BIT] && sel != SEL_RESERVED && sel <= SEL_MAX;
  assign fail_low = sel_ok && !general_io[sel];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;

  expiry_timer #(.UNIT_CYCLES(UNIT_CYCLES)) timer_a (
    .pclk(pclk),
    .presetn(presetn),
    .start(func_req.addr_set && q.st == ST_BILLBOARD),
    .run(q.st == ST_BILLBOARD),
    .load(q.tmr_a),
    .expired(exp_a)
  );

  expiry_timer #(.UNIT_CYCLES(UNIT_CYCLES)) timer_b (
    .pclk(pclk),
    .presetn(presetn),
    .start(func_req.alt_string_req && q.st == ST_BILLBOARD),
    .run(q.st == ST_BILLBOARD),
    .load(q.tmr_b),
    .expired(exp_b)
  );

  always_comb begin
    logic [IRQ_W-1:0] ev;
    ev = '0;
    d = q;
    d.grant = 1'b0;

    unique case (q.st)
      ST_NORMAL: begin
        if (fail_low) begin
          d.st = ST_DETACH_BB;
          d.hold = DW'(DETACH_HOLD - 1);
        end
      end
      ST_DETACH_BB: begin
        if (!sel_ok) begin
          d.st = ST_NORMAL;
        end else if (q.hold != '0) begin
          d.hold = q.hold - 1'b1;
        end else begin
          d.st = ST_BILLBOARD;
          ev[IRQ_ENTER_BB] = 1'b1;
        end
      end
      ST_BILLBOARD: begin
        d.grant = func_req.alt_string_req;
        ev[IRQ_EXPIRE_A] = exp_a;
        ev[IRQ_EXPIRE_B] = exp_b;
        // Disabling the feature mid-way is treated like an expiry so the port never
        // keeps the fallback role without an owner.
        if (exp_a || exp_b || !sel_ok) begin
          d.st = ST_DETACH_NORM;
          d.hold = DW'(DETACH_HOLD - 1);
        end
      end
      ST_DETACH_NORM: begin
        if (q.hold != '0) begin
          d.hold = q.hold - 1'b1;
        end else begin
          d.st = ST_WAIT_HIGH;
          ev[IRQ_RESTORED] = 1'b1;
        end
      end
      ST_WAIT_HIGH: begin
        if (!fail_low) begin
          d.st = ST_NORMAL;
        end
      end
      default: begin
        d.st = ST_NORMAL;
      end
    endcase

    if (setup) begin
      d.err = !mapped(paddr);
      unique case (paddr)
        OFS_CONTROL: d.rdata = {24'h0, q.ctrl};
        OFS_TIMER_A: d.rdata = {16'h0, q.tmr_a};
        OFS_TIMER_B: d.rdata = {16'h0, q.tmr_b};
        OFS_IRQ_STATUS: d.rdata = {{(32 - IRQ_W){1'b0}}, q.irq_stat};
        OFS_IRQ_ENABLE: d.rdata = {{(32 - IRQ_W){1'b0}}, q.irq_en};
        OFS_SEQ_STATE: d.rdata = {29'h0, q.st};
        default: d.rdata = 32'h0;
      endcase
    end

    if (wr && pstrb[0]) begin
      if (paddr == OFS_CONTROL) d.ctrl = pwdata[7:0] & CONTROL_MASK;
      if (paddr == OFS_IRQ_ENABLE) d.irq_en = pwdata[IRQ_W-1:0];
      if (paddr == OFS_IRQ_CLEAR) d.irq_stat = q.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    if (wr && paddr == OFS_TIMER_A) d.tmr_a = merge16(q.tmr_a, pwdata, pstrb);
    if (wr && paddr == OFS_TIMER_B) d.tmr_b = merge16(q.tmr_b, pwdata, pstrb);
    // A new event wins over a clear written in the same cycle.
    d.irq_stat = d.irq_stat | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= ST_NORMAL;
      q.ctrl <= CONTROL_RESET;
      q.tmr_a <= TIMER_RESET;
      q.tmr_b <= TIMER_RESET;
    end else begin
      q <= d;
    end
  end

  assign pready = penable;
  assign prdata = q.rdata;
  assign pslverr = q.err && psel && penable;
  assign irq = |(q.irq_stat & q.irq_en);

  always_comb begin
    func_rsp.attach = q.st != ST_DETACH_BB && q.st != ST_DETACH_NORM;
    func_rsp.billboard = q.st == ST_BILLBOARD;
    func_rsp.alt_string_grant = q.grant;
    func_rsp.bm_configured = BM_UNSPECIFIED;
  end
endmodule

// [logic/expiry_timer.sv]
// Purpose: One expiry timer counting in fixed units from a 16-bit load value.
// Assumes: start is a one-cycle pulse; run low cancels the count.
// Notes: The unit prescaler restarts with each start so the first unit is a full one.
module expiry_timer #(
  parameter int UNIT_CYCLES = bb_pkg::TIMER_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic run,
  input wire logic [15:0] load,
  // Result
  output logic expired
);
  import bb_pkg::*;
  localparam int PW = $clog2(UNIT_CYCLES + 1);

  initial begin
    if (UNIT_CYCLES < 1) $error("UNIT_CYCLES must be at least one");
  end

  typedef struct packed {
    logic armed;
    logic [PW-1:0] pre;
    logic [15:0] units;
    logic fire;
  } tmr_t;

  tmr_t q, d;

  always_comb begin
    d = q;
    d.fire = 1'b0;
    if (!run) begin
      d.armed = 1'b0;
    end else if (start) begin
      d.armed = 1'b1;
      d.pre = PW'(UNIT_CYCLES - 1);
      d.units = load;
    end else if (q.armed) begin
      if (q.pre != '0) begin
        d.pre = q.pre - 1'b1;
      end else begin
        d.pre = PW'(UNIT_CYCLES - 1);
        // A load of zero expires after the first unit rather than never.
        if (q.units <= 16'h0001) begin
          d.armed = 1'b0;
          d.fire = 1'b1;
        end else begin
          d.units = q.units - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.fire;
endmodule

// [verif/bb_props.sv]
// Purpose: Port-level checks of the fallback sequencer.
// Assumes: Zero-wait APB; parameters handed on by the bind.
// Notes: Detach length is counted in helper logic, not unrolled.
module bb_props #(
  parameter int UNIT_CYCLES = 4,
  parameter int DETACH_HOLD = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Function
  input wire bb_pkg::func_req_t func_req,
  input wire bb_pkg::func_rsp_t func_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import bb_pkg::*;
  logic [31:0] low_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_q <= 32'h0;
    else if (!func_rsp.attach) low_cnt_q <= low_cnt_q + 32'h1;
    else low_cnt_q <= 32'h0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_now_a: assert property (psel && penable |-> pready) else $error("no ready");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("stray error");
  err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
  // The role flips on the edge that ends or starts a detach, so one side of it is detached.
  detach_first_a: assert property ($changed(func_rsp.billboard) |->
    !(func_rsp.attach && $past(func_rsp.attach)))
    else $error("role swap while attached");
  hold_len_a: assert property ($rose(func_rsp.attach) |-> low_cnt_q == DETACH_HOLD)
    else $error("detach length");
  grant_cause_a: assert property (func_rsp.alt_string_grant |->
    $past(func_req.alt_string_req) && func_rsp.billboard) else $error("stray grant");
  grant_next_a: assert property (func_req.alt_string_req && func_rsp.billboard &&
    func_rsp.attach |=> func_rsp.alt_string_grant) else $error("no grant");
  bm_zero_a: assert property (func_rsp.bm_configured == 2'h0) else $error("configured");
endmodule
bind billboard_mode_sequencer bb_props #(.UNIT_CYCLES(UNIT_CYCLES), .DETACH_HOLD(DETACH_HOLD))
  props_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .func_req(func_req), .func_rsp(func_rsp));

// [verif/billboard_mode_sequencer_tb.sv]
// Purpose: Self-checking bench of the fallback sequencer.
// Assumes: Shortened unit and detach counts.
// Notes: Timers are loaded small so expiry is seen in tens of cycles.
module billboard_mode_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [16:0] general_io;
  func_req_t func_req;
  func_rsp_t func_rsp;
  logic [4:0] pin_sel;
  logic fail_req, host_addr, host_str;
  int bad_count, compares, cycles;
  billboard_mode_sequencer #(.UNIT_CYCLES(4), .DETACH_HOLD(3)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .general_io(general_io), .func_req(func_req), .func_rsp(func_rsp), .irq(irq));
  far_side far_u (.pclk(pclk), .presetn(presetn), .pin_sel(pin_sel), .fail_req(fail_req),
    .host_addr(host_addr), .host_str(host_str), .func_rsp(func_rsp),
    .general_io(general_io), .func_req(func_req));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task test_done;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task wait_rsp(input logic [1:0] v, output int n);
    n = 0;
    while ({func_rsp.attach, func_rsp.billboard} !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk({30'h0, func_rsp.attach, func_rsp.billboard}, {30'h0, v});
  endtask
  task pulse(input logic s);
    @(posedge pclk);
    if (s) host_str <= 1'b1;
    else host_addr <= 1'b1;
    @(posedge pclk);
    host_str <= 1'b0;
    host_addr <= 1'b0;
  endtask
  task t_reset;
    logic [31:0] r;
    logic e;
    rd_chk(OFS_CONTROL, 32'h14);
    rd_chk(OFS_TIMER_A, 32'h7d0);
    rd_chk(OFS_TIMER_B, 32'h7d0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask
  task t_ignored;
    int n;
    pin_sel <= 5'h0a;
    fail_req <= 1'b1;
    repeat (20) @(posedge pclk);
    wait_rsp(2'b10, n);
    wr(OFS_CONTROL, 32'h13);
    pin_sel <= 5'h09;
    repeat (20) @(posedge pclk);
    wait_rsp(2'b10, n);
    fail_req <= 1'b0;
  endtask
  task t_timer_a;
    int n;
    wr(OFS_TIMER_A, 32'h3);
    wr(OFS_IRQ_ENABLE, 32'hf);
    pin_sel <= 5'h0a;
    fail_req <= 1'b1;
    wr(OFS_CONTROL, 32'h15);
    wait_rsp(2'b00, n);
    wait_rsp(2'b11, n);
    chk({31'h0, irq}, 32'h1);
    pulse(1'b0);
    wait_rsp(2'b10, n);
    chk({31'h0, n >= 12}, 32'h1);
    rd_chk(OFS_IRQ_STATUS, 32'hb);
    repeat (30) @(posedge pclk);
    wait_rsp(2'b10, n);
    rd_chk(OFS_SEQ_STATE, 32'h4);
    wr(OFS_IRQ_ENABLE, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'hf);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
  endtask
  task t_timer_b;
    int n;
    logic g;
    fail_req <= 1'b0;
    repeat (5) @(posedge pclk);
    pin_sel <= 5'h10;
    wr(OFS_CONTROL, 32'h21);
    wr(OFS_TIMER_B, 32'h2);
    fail_req <= 1'b1;
    wait_rsp(2'b11, n);
    g = 1'b0;
    pulse(1'b1);
    repeat (3) begin
      @(posedge pclk);
      if (func_rsp.alt_string_grant === 1'b1) g = 1'b1;
    end
    chk({31'h0, g}, 32'h1);
    wait_rsp(2'b10, n);
    rd_chk(OFS_IRQ_STATUS, 32'hd);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_sel, fail_req, host_addr, host_str} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ignored();
    t_timer_a();
    t_timer_b();
    test_done();
  end
endmodule

// [verif/far_side.sv]
// Purpose: Power controller and host standing beside the sequencer.
// Assumes: Commands come from the bench one cycle ahead.
// Notes: The host only talks to an attached function, as a real one would.
module far_side (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands
  input wire logic [4:0] pin_sel,
  input wire logic fail_req,
  input wire logic host_addr,
  input wire logic host_str,
  // Block side
  input wire bb_pkg::func_rsp_t func_rsp,
  output logic [16:0] general_io,
  output bb_pkg::func_req_t func_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import bb_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_io <= '1;
      func_req <= '0;
    end else begin
      general_io <= ~(17'h1 << pin_sel) | {17{~fail_req}};
      func_req.addr_set <= host_addr & func_rsp.attach;
      func_req.alt_string_req <= host_str & func_rsp.attach;
    end
  end
endmodule
